// >>> core/fault_pkg.sv
// Constants shared by the stepper fault shutdown block.
package fault_pkg;

  // Core clock and the internal chopper oscillator rate.
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int OSC_FREQ_KHZ = 1600;
  // Half period of the oscillator in core cycles, rounded down.
  localparam int OSC_HALF_DIV = CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
  // Oscillator cycles an overcurrent must persist before it trips.
  localparam int OC_MASK_CYCLES = 4;

  // Register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h08;

  // Event bits, shared by the status and mask registers.
  localparam int EVT_W = 4;
  localparam int EVT_THERMAL = 0;
  localparam int EVT_OC_A = 1;
  localparam int EVT_OC_B = 2;
  localparam int EVT_SUPPLY = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  // Live state register layout.
  localparam int STATE_W = 6;
  localparam int ST_THERMAL = 0;
  localparam int ST_OC_A = 1;
  localparam int ST_OC_B = 2;
  localparam int ST_STANDBY = 3;
  localparam int ST_MOTOR_OK = 4;
  localparam int ST_LOGIC_OK = 5;

  // Bus encodings.
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'h0;

  // Regulated current step, percent of full scale.
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP0 = 7'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP1 = 7'h26;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP2 = 7'h47;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP3 = 7'h64;

endpackage : fault_pkg

// >>> core/overcurrent_filter.sv
// Per-phase overcurrent masking counter and trip latch.
`timescale 1ns/1ps
module overcurrent_filter #(
  parameter int MASK_CYCLES = fault_pkg::OC_MASK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic osc_tick_in,
  input wire logic clear_in,
  input wire logic raw_in,
  // Result
  output logic trip_out
);
  import fault_pkg::*;

  localparam int CNT_W = $clog2(MASK_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MASK_CYCLES);

  if (MASK_CYCLES < 1) begin : bad_mask
    $error("MASK_CYCLES must be at least one");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_trip;
  wire persisted = raw_in && osc_tick_in && (count == CNT_LAST - 1'b1);

  assign next_count = !raw_in ? '0 :
                      (osc_tick_in && count != CNT_LAST) ? count + 1'b1 :
                      count;
  // latch phase trip
  // A trip cannot latch while standby is low, since osc_tick is held low then; otherwise set wins over clear_in.
  assign next_trip = persisted || (trip_out && !clear_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      trip_out <= 1'b0;
    end else begin
      count <= next_count;
      trip_out <= next_trip;
    end
  end

endmodule : overcurrent_filter

// >>> core/stepper_fault_shutdown.sv
// Protection, shutdown and output gating of a two-phase stepper driver.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// - A thermal trip turns off every output of both phases and holds.
// - The thermal latch clears only on reset or standby driven low.
// - Either supply monitor reporting low turns off every output of both phases.
// - Each phase has its own overcurrent trip, latched, off that phase.
// - An overcurrent latch clears only on reset or standby driven low.
// - Overcurrent must persist four oscillator cycles before tripping.
// - Both step selects low put that phase at high impedance.
// - Direction high drives positive to negative, low the reverse.
// - Standby low stops the chopper oscillator and all drivers.
module stepper_fault_shutdown #(
  parameter int OSC_DIV = fault_pkg::OSC_HALF_DIV,
  parameter int MASK_CYCLES = fault_pkg::OC_MASK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Controller inputs
  input wire logic phase_a_step_sel0_in,
  input wire logic phase_a_step_sel1_in,
  input wire logic phase_a_dir_in,
  input wire logic phase_b_step_sel0_in,
  input wire logic phase_b_step_sel1_in,
  input wire logic phase_b_dir_in,
  input wire logic standby_n_in,
  // Monitors
  input wire logic thermal_trip_in,
  input wire logic overcurrent_trip_a_in,
  input wire logic overcurrent_trip_b_in,
  input wire logic motor_supply_ok_in,
  input wire logic logic_supply_ok_in,
  // Bridge drive, phase A
  output logic phase_a_drive_pos_out,
  output logic phase_a_drive_neg_out,
  output logic [1:0] phase_a_step_out,
  output logic [fault_pkg::LEVEL_W-1:0] phase_a_level_out,
  // Bridge drive, phase B
  output logic phase_b_drive_pos_out,
  output logic phase_b_drive_neg_out,
  output logic [1:0] phase_b_step_out,
  output logic [fault_pkg::LEVEL_W-1:0] phase_b_level_out,
  // Oscillator and interrupt
  output logic chopper_osc_out,
  output logic irq_out,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [fault_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  import fault_pkg::*;

  if (OSC_DIV < 1) begin : bad_div
    $error("OSC_DIV must be at least one");
  end

  localparam int DIV_W = $clog2(OSC_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

  // Step code is {sel0, sel1}, so low-high reads as step one.
  function automatic logic [LEVEL_W-1:0] step_level(
    input logic [1:0] code
  );
    unique case (code)
      2'h0: step_level = LEVEL_STEP0;
      2'h1: step_level = LEVEL_STEP1;
      2'h2: step_level = LEVEL_STEP2;
      2'h3: step_level = LEVEL_STEP3;
    endcase
  endfunction : step_level

  //////////////////////////////////////////////////////////////////////////
  // Chopper oscillator.

  logic [DIV_W-1:0] div_count;
  logic [DIV_W-1:0] next_div_count;
  logic next_osc;
  wire div_wrap = (div_count == DIV_LAST);
  // A tick marks each rising edge of the oscillator.
  wire osc_tick = standby_n_in && div_wrap && !chopper_osc_out;

  assign next_div_count = (!standby_n_in || div_wrap) ? '0 :
                          div_count + 1'b1;
  assign next_osc = !standby_n_in ? 1'b0 :
                    div_wrap ? !chopper_osc_out : chopper_osc_out;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_count <= '0;
      chopper_osc_out <= 1'b0;
    end else begin
      div_count <= next_div_count;
      chopper_osc_out <= next_osc;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trip latches.

  logic thermal_latch;
  logic next_thermal_latch;
  logic oc_latch_a;
  logic oc_latch_b;
  wire trip_clear = !standby_n_in;

  assign next_thermal_latch = thermal_trip_in ||
                              (thermal_latch && !trip_clear);

  overcurrent_filter #(
    .MASK_CYCLES(MASK_CYCLES)
  ) filter_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .osc_tick_in(osc_tick),
    .clear_in(trip_clear),
    .raw_in(overcurrent_trip_a_in),
    .trip_out(oc_latch_a)
  );

  overcurrent_filter #(
    .MASK_CYCLES(MASK_CYCLES)
  ) filter_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .osc_tick_in(osc_tick),
    .clear_in(trip_clear),
    .raw_in(overcurrent_trip_b_in),
    .trip_out(oc_latch_b)
  );

  //////////////////////////////////////////////////////////////////////////
  // Output gating.

  wire supply_ok = motor_supply_ok_in && logic_supply_ok_in;
  wire chip_on = supply_ok && standby_n_in && !thermal_latch;
  wire on_a = chip_on && !oc_latch_a;
  wire on_b = chip_on && !oc_latch_b;
  wire [1:0] code_a = {phase_a_step_sel0_in, phase_a_step_sel1_in};
  wire [1:0] code_b = {phase_b_step_sel0_in, phase_b_step_sel1_in};
  wire drive_a = on_a && (code_a != 2'h0);
  wire drive_b = on_b && (code_b != 2'h0);
  wire next_a_pos = drive_a && phase_a_dir_in;
  wire next_a_neg = drive_a && !phase_a_dir_in;
  wire next_b_pos = drive_b && phase_b_dir_in;
  wire next_b_neg = drive_b && !phase_b_dir_in;
  wire [1:0] next_a_step = drive_a ? code_a : 2'h0;
  wire [1:0] next_b_step = drive_b ? code_b : 2'h0;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      thermal_latch <= 1'b0;
      phase_a_drive_pos_out <= 1'b0;
      phase_a_drive_neg_out <= 1'b0;
      phase_b_drive_pos_out <= 1'b0;
      phase_b_drive_neg_out <= 1'b0;
      phase_a_step_out <= 2'h0;
      phase_b_step_out <= 2'h0;
      phase_a_level_out <= LEVEL_STEP0;
      phase_b_level_out <= LEVEL_STEP0;
    end else begin
      thermal_latch <= next_thermal_latch;
      phase_a_drive_pos_out <= next_a_pos;
      phase_a_drive_neg_out <= next_a_neg;
      phase_b_drive_pos_out <= next_b_pos;
      phase_b_drive_neg_out <= next_b_neg;
      phase_a_step_out <= next_a_step;
      phase_b_step_out <= next_b_step;
      phase_a_level_out <= step_level(next_a_step);
      phase_b_level_out <= step_level(next_b_step);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Events and interrupt.

  logic thermal_prev;
  logic oc_a_prev;
  logic oc_b_prev;
  logic supply_prev;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] next_mask;
  logic [EVT_W-1:0] events;

  always_comb begin
    events = '0;
    events[EVT_THERMAL] = thermal_latch && !thermal_prev;
    events[EVT_OC_A] = oc_latch_a && !oc_a_prev;
    events[EVT_OC_B] = oc_latch_b && !oc_b_prev;
    events[EVT_SUPPLY] = supply_prev && !supply_ok;
  end

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave, zero wait states.

  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  wire addr_phase = hsel_in && hready_in && (htrans_in[1] != 1'b0);
  wire wr_status = wr_pend && (wr_addr == ADDR_STATUS);
  wire wr_mask = wr_pend && (wr_addr == ADDR_MASK);
  wire [EVT_W-1:0] clr_bits = wr_status ? hwdata_in[EVT_W-1:0] : '0;
  wire [STATE_W-1:0] state_bits = {logic_supply_ok_in,
                                   motor_supply_ok_in,
                                   !standby_n_in,
                                   oc_latch_b,
                                   oc_latch_a,
                                   thermal_latch};
  wire [31:0] rd_mux =
    (haddr_in == ADDR_STATUS) ? {{(32-EVT_W){1'b0}}, status} :
    (haddr_in == ADDR_MASK) ? {{(32-EVT_W){1'b0}}, mask} :
    (haddr_in == ADDR_STATE) ? {{(32-STATE_W){1'b0}}, state_bits} :
    32'h0000_0000;
  wire rd_take = addr_phase && !hwrite_in;
  wire [31:0] next_rdata = rd_take ? rd_mux : hrdata_out;

  // Set wins over a write-one-to-clear in the same cycle.
  assign next_status = (status & ~clr_bits) | events;
  assign next_mask = wr_mask ? hwdata_in[EVT_W-1:0] : mask;
  wire next_irq = |(next_status & next_mask);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      thermal_prev <= 1'b0;
      oc_a_prev <= 1'b0;
      oc_b_prev <= 1'b0;
      supply_prev <= 1'b0;
      status <= EVT_RESET;
      mask <= EVT_RESET;
      irq_out <= 1'b0;
    end else begin
      thermal_prev <= thermal_latch;
      oc_a_prev <= oc_latch_a;
      oc_b_prev <= oc_latch_b;
      supply_prev <= supply_ok;
      status <= next_status;
      mask <= next_mask;
      irq_out <= next_irq;
    end
  end

  // Reads are sampled in the address phase so hrdata is a flop output.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end else begin
      wr_pend <= addr_phase && hwrite_in;
      wr_addr <= haddr_in;
      hrdata_out <= next_rdata;
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end
  end

endmodule : stepper_fault_shutdown

// >>> testbench/sfs_checker_assertions.sv
// Port-level assertions for the stepper fault shutdown block.
`timescale 1ns/1ps
module sfs_checker #(
  parameter int MASK_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Watched inputs
  input wire logic phase_a_step_sel0_in,
  input wire logic phase_a_step_sel1_in,
  input wire logic phase_a_dir_in,
  input wire logic standby_n_in,
  input wire logic thermal_trip_in,
  input wire logic overcurrent_trip_a_in,
  input wire logic motor_supply_ok_in,
  input wire logic logic_supply_ok_in,
  // Watched outputs
  input wire logic phase_a_drive_pos_out,
  input wire logic phase_a_drive_neg_out,
  input wire logic [1:0] phase_a_step_out,
  input wire logic [fault_pkg::LEVEL_W-1:0] phase_a_level_out,
  input wire logic phase_b_drive_pos_out,
  input wire logic phase_b_drive_neg_out,
  input wire logic chopper_osc_out
);
  import fault_pkg::*;
  logic a_off, all_off, sup_ok, osc_q, th_seen, oc_seen;
  logic [3:0] oc_cnt;
  logic [LEVEL_W-1:0] exp_lvl;
  assign a_off = !phase_a_drive_pos_out && !phase_a_drive_neg_out;
  assign all_off = a_off && !phase_b_drive_pos_out && !phase_b_drive_neg_out;
  assign sup_ok = motor_supply_ok_in && logic_supply_ok_in;
  assign exp_lvl = phase_a_step_out == 2'h0 ? LEVEL_STEP0 :
    phase_a_step_out == 2'h1 ? LEVEL_STEP1 :
    phase_a_step_out == 2'h2 ? LEVEL_STEP2 : LEVEL_STEP3;
  ////////////////////////////////////////////////////////////////////////////
  // Rises are counted, not ticks, so one extra rise covers tick skew.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_q <= 1'b0;
      oc_cnt <= 4'h0;
      th_seen <= 1'b0;
      oc_seen <= 1'b0;
    end else begin
      osc_q <= chopper_osc_out;
      if (!overcurrent_trip_a_in) begin
        oc_cnt <= 4'h0;
      end else if (chopper_osc_out && !osc_q && oc_cnt != 4'hf) begin
        oc_cnt <= oc_cnt + 4'h1;
      end
      if (oc_cnt > MASK_CYCLES) begin
        oc_seen <= 1'b1;
      end else if (!standby_n_in && !overcurrent_trip_a_in) begin
        oc_seen <= 1'b0;
      end
      if (thermal_trip_in) begin
        th_seen <= 1'b1;
      end else if (!standby_n_in) begin
        th_seen <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_thermal_off:
    assert property (thermal_trip_in |-> ##3 all_off)
    else $error("thermal trip left a driver on");
  chk_thermal_hold:
    assert property (th_seen |-> ##2 all_off)
    else $error("thermal latch let go early");
  chk_supply_off:
    assert property (!sup_ok |=> all_off)
    else $error("low supply left a driver on");
  chk_oc_hold:
    assert property (oc_seen |-> a_off)
    else $error("overcurrent did not hold phase a off");
  chk_zero_hiz:
    assert property (!phase_a_step_sel0_in && !phase_a_step_sel1_in
      |=> a_off && phase_a_step_out == 2'h0)
    else $error("zero step left phase a driven");
  chk_dir_polar:
    assert property (!a_off |-> phase_a_drive_pos_out == $past(phase_a_dir_in)
      && phase_a_drive_neg_out != phase_a_drive_pos_out)
    else $error("phase a polarity wrong");
  chk_standby_off:
    assert property (!standby_n_in |=> all_off && !chopper_osc_out)
    else $error("standby left drive or oscillator on");
  chk_level_map:
    assert property (phase_a_level_out == exp_lvl && (phase_a_step_out == 2'h0
      || phase_a_step_out == $past({phase_a_step_sel0_in, phase_a_step_sel1_in})))
    else $error("phase a step or level wrong");
  cover property (oc_seen);
  cover property (th_seen ##1 !th_seen);
  cover property (!sup_ok ##1 sup_ok);
endmodule : sfs_checker

// >>> testbench/step_ctrl_model.sv
// Step sequencing controller model driving the block's control inputs.
`timescale 1ns/1ps
module step_ctrl_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Requests: {sel0, sel1, dir} per phase, and sleep
  input wire logic [2:0] a_req_in,
  input wire logic [2:0] b_req_in,
  input wire logic sleep_in,
  // Lines toward the block
  output logic [2:0] a_out,
  output logic [2:0] b_out,
  output logic standby_n_out
);
  // Recovery from a trip is by pulling standby low.
  // Selects stay low through power-up so no phase drives on release.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_out <= 3'h0;
      b_out <= 3'h0;
      standby_n_out <= 1'b0;
    end else begin
      a_out <= a_req_in;
      b_out <= b_req_in;
      standby_n_out <= !sleep_in;
    end
  end
endmodule : step_ctrl_model

// >>> testbench/stepper_fault_shutdown_tb_top.sv
// Self-checking bench for the stepper fault shutdown block.
`timescale 1ns/1ps
module stepper_fault_shutdown_tb_top;
  import fault_pkg::*;
  localparam int MASK_CYCLES = 4;
  localparam int OSC_DIV = 2;
  logic clk_in = 1'b0, rst_n_in = 1'b1, thermal_trip_in = 1'b0;
  logic overcurrent_trip_a_in = 1'b0, overcurrent_trip_b_in = 1'b0;
  logic motor_supply_ok_in = 1'b1, logic_supply_ok_in = 1'b1;
  logic hsel_in = 1'b0, hwrite_in = 1'b0, sleep = 1'b0;
  logic [7:0] haddr_in = 8'h00;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2, a_req = 3'h0, b_req = 3'h0;
  logic [31:0] hwdata_in = 32'h0, rd, hrdata_out, osc_hi = 32'h0;
  logic hready_in, hreadyout_out, hresp_out, irq_out, chopper_osc_out;
  logic phase_a_step_sel0_in, phase_a_step_sel1_in, phase_a_dir_in;
  logic phase_b_step_sel0_in, phase_b_step_sel1_in, phase_b_dir_in;
  logic standby_n_in, phase_a_drive_pos_out, phase_a_drive_neg_out;
  logic phase_b_drive_pos_out, phase_b_drive_neg_out;
  logic [1:0] phase_a_step_out, phase_b_step_out;
  logic [LEVEL_W-1:0] phase_a_level_out, phase_b_level_out;
  logic [10:0] got_a, got_b;
  int fails = 0, tests_run = 0;
  always #4 clk_in = ~clk_in;
  assign hready_in = hreadyout_out;
  assign got_a = {phase_a_drive_pos_out, phase_a_drive_neg_out,
    phase_a_step_out, phase_a_level_out};
  assign got_b = {phase_b_drive_pos_out, phase_b_drive_neg_out,
    phase_b_step_out, phase_b_level_out};
  step_ctrl_model u_ctrl (.clk_in, .rst_n_in, .a_req_in(a_req),
    .b_req_in(b_req), .sleep_in(sleep), .standby_n_out(standby_n_in),
    .a_out({phase_a_step_sel0_in, phase_a_step_sel1_in, phase_a_dir_in}),
    .b_out({phase_b_step_sel0_in, phase_b_step_sel1_in, phase_b_dir_in}));
  // A short oscillator divider keeps the mask window to a few cycles.
  stepper_fault_shutdown #(.OSC_DIV(OSC_DIV), .MASK_CYCLES(MASK_CYCLES))
    u_dut (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic rdy();
    @(posedge clk_in);
    // Only the watchdog may end a wait for the slave.
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
  endtask : rdy
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    rdy();
    htrans_in <= HTRANS_IDLE;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    rdy();
    rd = hrdata_out;
    chk("hresp", hresp_out, HRESP_OKAY);
  endtask : bus
  task automatic rdchk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk
  function automatic logic [10:0] drv(input logic [2:0] r, input logic en);
    logic [6:0] l;
    l = r[2:1] == 2'h1 ? LEVEL_STEP1 :
      r[2:1] == 2'h2 ? LEVEL_STEP2 : LEVEL_STEP3;
    if (!en || r[2:1] == 2'h0) return 11'h0;
    return {r[0], !r[0], r[2:1], l};
  endfunction : drv
  task automatic ph(input logic ea, eb);
    chk("phase_a", got_a, drv(a_req, ea));
    chk("phase_b", got_b, drv(b_req, eb));
  endtask : ph
  task automatic wake();
    sleep <= 1'b1;
    tick(2);
    sleep <= 1'b0;
    tick(6);
  endtask : wake
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_in <= 1'b0;
    void'($urandom(32'h5a88));
    tick(20);
    rst_n_in <= 1'b1;
    tick(2);
    rdchk("state", ADDR_STATE, 32'h30);
    rdchk("mask", ADDR_MASK, 32'h0);
    bus(1'b1, 8'h0c, 32'hffffffff);
    rdchk("unmapped", 8'h0c, 32'h0);
    for (int i = 0; i < 16; i++) begin
      a_req <= i < 8 ? 3'(i) : 3'($urandom);
      b_req <= 3'($urandom);
      tick(4);
      ph(1'b1, 1'b1);
    end
    bus(1'b1, ADDR_MASK, 32'h7);
    rdchk("mask", ADDR_MASK, 32'h7);
    a_req <= 3'h7;
    b_req <= 3'h6;
    // Either monitor low forces every driver off.
    for (int m = 0; m < 2; m++) begin
      {logic_supply_ok_in, motor_supply_ok_in} <= 2'(m + 1) ^ 2'h3;
      tick(4);
      ph(1'b0, 1'b0);
      chk("irq", irq_out, 1'b0);
      {logic_supply_ok_in, motor_supply_ok_in} <= 2'h3;
      tick(4);
      ph(1'b1, 1'b1);
      rdchk("status", ADDR_STATUS, 32'h8);
      bus(1'b1, ADDR_STATUS, 32'h8);
      rdchk("status", ADDR_STATUS, 32'h0);
    end
    // A one-cycle trip stays latched until standby.
    thermal_trip_in <= 1'b1;
    tick(1);
    thermal_trip_in <= 1'b0;
    tick(6);
    ph(1'b0, 1'b0);
    chk("irq", irq_out, 1'b1);
    rdchk("state", ADDR_STATE, 32'h31);
    wake();
    ph(1'b1, 1'b1);
    bus(1'b1, ADDR_STATUS, 32'h1);
    tick(2);
    chk("irq", irq_out, 1'b0);
    // Spikes pass, a long one trips one phase.
    for (int p = 0; p < 2; p++) begin
      {overcurrent_trip_b_in, overcurrent_trip_a_in} <= 2'(p + 1);
      tick(8);
      {overcurrent_trip_b_in, overcurrent_trip_a_in} <= 2'h0;
      tick(3);
      ph(1'b1, 1'b1);
      {overcurrent_trip_b_in, overcurrent_trip_a_in} <= 2'(p + 1);
      tick(30);
      {overcurrent_trip_b_in, overcurrent_trip_a_in} <= 2'h0;
      tick(10);
      ph(p == 1, p == 0);
      chk("irq", irq_out, 1'b1);
      rdchk("status", ADDR_STATUS, 32'(2 << p));
      wake();
      ph(1'b1, 1'b1);
      bus(1'b1, ADDR_STATUS, 32'hf);
    end
    // A restart in mid-run also releases a thermal trip.
    thermal_trip_in <= 1'b1;
    tick(1);
    thermal_trip_in <= 1'b0;
    tick(3);
    ph(1'b0, 1'b0);
    rst_n_in <= 1'b0;
    tick(2);
    rst_n_in <= 1'b1;
    tick(6);
    ph(1'b1, 1'b1);
    rdchk("state", ADDR_STATE, 32'h30);
    rdchk("mask", ADDR_MASK, 32'h0);
    // The oscillator runs at half duty until standby stops it.
    for (int k = 0; k < 4 * OSC_DIV; k++) begin
      osc_hi <= osc_hi + 32'(chopper_osc_out);
      tick(1);
    end
    chk("osc_high", osc_hi, 32'(2 * OSC_DIV));
    sleep <= 1'b1;
    tick(3);
    for (int k = 0; k < 12; k++) begin
      chk("osc", chopper_osc_out, 1'b0);
      tick(1);
    end
    ph(1'b0, 1'b0);
    rdchk("state", ADDR_STATE, 32'h38);
    close_out();
  end
  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule : stepper_fault_shutdown_tb_top
bind stepper_fault_shutdown sfs_checker #(.MASK_CYCLES(MASK_CYCLES)) u_chk (.*);
